// File: dar_defs.svh
// dar_defs.svh: named constants of the dual result serial readout
// Assumes a 200 MHz local clock on the host end and a host-made serial clock
`ifndef DAR_DEFS_SVH
`define DAR_DEFS_SVH

// ****************************************
// Word and frame layout
// ****************************************
`define DAR_RES_W         14
`define DAR_CNT_W         5
`define DAR_FRAME_EDGES   19
`define DAR_CFG_EDGES     14
`define DAR_SAMPLE_FIRST  2
`define DAR_SAMPLE_LAST   15
`define DAR_BUF_DEPTH     2
`define DAR_BUF_CNT_W     2
`define DAR_TMR_W         16

// ****************************************
// Times in their own units, cycle counts derived
// ****************************************
`define DAR_CLK_NS        5
`define DAR_SCLK_MIN_KHZ  200
`define DAR_SCLK_MAX_MHZ  34
`define DAR_SCLK_SLOW_MHZ 20
`define DAR_CONV_MAX_NS   560
`define DAR_CONV_SLOW_NS  950
`define DAR_OFF_EDGE_NS   15
`define DAR_ACCESS_LO_NS  29
`define DAR_ACCESS_HI_NS  23
`define DAR_DIN_SETUP_NS  3
`define DAR_OFF_CS_NS     13
`define DAR_QUIET_NS      13
`define DAR_CS_SETUP_NS   10
`define DAR_CAL_HIGH_NS   2000
`define DAR_CAL_TO_CS_NS  2000
`define DAR_PWRUP_NS      240000
`define DAR_PWRUP_EXT_NS  15000
`define DAR_CYC_MIN(ns)   (((ns) + `DAR_CLK_NS - 1) / `DAR_CLK_NS)
// Half period of the serial clock: 4 cycles gives 25 MHz at even duty
`define DAR_SCLK_HALF     4

`endif

// File: dar_pkg.sv
// dar_pkg.sv: types shared by both ends of the readout link
// Assumes dar_defs.svh is found on the include path
`default_nettype none
`include "dar_defs.svh"
package dar_pkg;
    // Result and configuration word
    typedef logic [`DAR_RES_W-1:0] dar_word_t;
    // Host sequencer states, one-hot
    typedef enum logic [5:0]
    {
        HS_PWRUP = 6'h01,
        HS_IDLE  = 6'h02,
        HS_CAL   = 6'h04,
        HS_SETUP = 6'h08,
        HS_FRAME = 6'h10,
        HS_QUIET = 6'h20
    } dar_hstate_e;
endpackage
`default_nettype wire

// File: dar_if.sv
// dar_if.sv: pins between host and converter readout
// Assumes the bench resolves each result line from its data and enable
`timescale 1ns/1ps
`default_nettype none
interface dar_if;
    logic cs_n;
    logic sclk;
    logic cfg_din;
    logic cal;
    logic res_first_o;
    logic res_first_oe;
    logic res_second_o;
    logic res_second_oe;

    // Host drives the frame, reads both result lines
    modport host
    (
        output cs_n, sclk, cfg_din, cal,
        input  res_first_o, res_first_oe, res_second_o, res_second_oe
    );
    // Converter end answers on the result lines
    modport dev
    (
        input  cs_n, sclk, cfg_din, cal,
        output res_first_o, res_first_oe, res_second_o, res_second_oe
    );
endinterface
`default_nettype wire

// File: dar_dev.sv
// dar_dev.sv: converter end of the dual result serial readout
// Assumes the host makes the serial clock, which stands still between frames
`timescale 1ns/1ps
`default_nettype none
`include "dar_defs.svh"
module dar_dev
(
    input  wire logic              i_clock,
    input  wire logic              i_resetn,
    input  wire logic              i_sample_valid,
    input  wire dar_pkg::dar_word_t i_sample_first,
    input  wire dar_pkg::dar_word_t i_sample_second,
    output logic                   o_sample_ready,
    output dar_pkg::dar_word_t     o_cfg_word,
    output logic                   o_frame_done,
    output logic                   o_cal_start,
    dar_if.dev                     bus
);
    import dar_pkg::*;

    // ****************************************
    // Local clock side
    // ****************************************
    logic      req_r;
    logic      ack_s1_r;
    logic      ack_s2_r;
    logic      done_s1_r;
    logic      done_s2_r;
    logic      done_s3_r;
    logic      cal_s1_r;
    logic      cal_s2_r;
    logic      cal_s3_r;
    logic      done_pls_r;
    logic      cal_pls_r;
    dar_word_t hold_a_r;
    dar_word_t hold_b_r;
    dar_word_t cfg_out_r;

    // ****************************************
    // Serial clock side
    // ****************************************
    logic                 rq_s1_r;
    logic                 rq_s2_r;
    logic                 ack_r;
    logic                 done_tgl_r;
    logic [`DAR_CNT_W-1:0] cnt_r;
    logic                 end_r;
    logic                 out_a_r;
    logic                 out_b_r;
    dar_word_t            sh_a_r;
    dar_word_t            sh_b_r;
    dar_word_t            last_a_r;
    dar_word_t            last_b_r;
    dar_word_t            cfg_sh_r;
    dar_word_t            cfg_hold_r;

    // Frame decode
    wire first_edge = cnt_r == '0;
    wire last_edge  = cnt_r == `DAR_CNT_W'(`DAR_FRAME_EDGES - 1);
    wire cfg_edge   = cnt_r < `DAR_CNT_W'(`DAR_CFG_EDGES);
    wire new_word   = rq_s2_r != ack_r;
    wire sample_go  = i_sample_valid & o_sample_ready;
    wire dar_word_t word_a = new_word ? hold_a_r : last_a_r;
    wire dar_word_t word_b = new_word ? hold_b_r : last_b_r;

    // Sample hand-off: word held still while its toggle travels
    assign o_sample_ready = req_r == ack_s2_r;
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            req_r    <= 1'b0;
            hold_a_r <= '0;
            hold_b_r <= '0;
        end
        else if (sample_go)
        begin
            req_r    <= ~req_r;
            hold_a_r <= i_sample_first;
            hold_b_r <= i_sample_second;
        end
    end

    // Synchronisers into the local clock
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            {ack_s1_r, ack_s2_r}              <= '0;
            {done_s1_r, done_s2_r, done_s3_r} <= '0;
            {cal_s1_r, cal_s2_r, cal_s3_r}    <= '0;
        end
        else
        begin
            {ack_s1_r, ack_s2_r}              <= {ack_r, ack_s1_r};
            {done_s1_r, done_s2_r, done_s3_r} <= {done_tgl_r, done_s1_r, done_s2_r};
            {cal_s1_r, cal_s2_r, cal_s3_r}    <= {bus.cal, cal_s1_r, cal_s2_r};
        end
    end

    // Frame done with its configuration word, and calibration start
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            done_pls_r <= 1'b0;
            cal_pls_r  <= 1'b0;
            cfg_out_r  <= '0;
        end
        else
        begin
            done_pls_r <= done_s2_r ^ done_s3_r;
            cal_pls_r  <= cal_s2_r & ~cal_s3_r;
            if (done_s2_r ^ done_s3_r)
                cfg_out_r <= cfg_hold_r;
        end
    end
    assign o_frame_done = done_pls_r;
    assign o_cal_start  = cal_pls_r;
    assign o_cfg_word   = cfg_out_r;

    // Frame state, cleared by chip select high
    always_ff @(negedge bus.sclk or posedge bus.cs_n)
    begin
        if (bus.cs_n)
        begin
            cnt_r   <= '0;
            end_r   <= 1'b0;
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
            sh_a_r  <= '0;
            sh_b_r  <= '0;
        end
        else
        begin
            if (!last_edge && !end_r)
                cnt_r <= cnt_r + `DAR_CNT_W'(1);
            if (last_edge)
                end_r <= 1'b1;
            if (first_edge)
            begin
                sh_a_r  <= word_a;
                sh_b_r  <= word_b;
                out_a_r <= 1'b0;
                out_b_r <= 1'b0;
            end
            else
            begin
                out_a_r <= sh_a_r[`DAR_RES_W-1];
                out_b_r <= sh_b_r[`DAR_RES_W-1];
                sh_a_r  <= {sh_a_r[`DAR_RES_W-2:0], 1'b0};
                sh_b_r  <= {sh_b_r[`DAR_RES_W-2:0], 1'b0};
            end
        end
    end

    // Persistent serial side state: sample toggle, configuration capture
    always_ff @(negedge bus.sclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            {rq_s1_r, rq_s2_r} <= '0;
            ack_r      <= 1'b0;
            done_tgl_r <= 1'b0;
            last_a_r   <= '0;
            last_b_r   <= '0;
            cfg_sh_r   <= '0;
            cfg_hold_r <= '0;
        end
        else
        begin
            {rq_s1_r, rq_s2_r} <= {req_r, rq_s1_r};
            if (!bus.cs_n && first_edge && new_word)
            begin
                ack_r    <= rq_s2_r;
                last_a_r <= hold_a_r;
                last_b_r <= hold_b_r;
            end
            if (!bus.cs_n && cfg_edge)
                cfg_sh_r <= {cfg_sh_r[`DAR_RES_W-2:0], bus.cfg_din};
            if (!bus.cs_n && last_edge && !end_r)
            begin
                cfg_hold_r <= cfg_sh_r;
                done_tgl_r <= ~done_tgl_r;
            end
        end
    end

    // Result lines driven only inside a frame, before its last edge
    assign bus.res_first_o   = out_a_r;
    assign bus.res_second_o  = out_b_r;
    assign bus.res_first_oe  = ~bus.cs_n & ~end_r;
    assign bus.res_second_oe = ~bus.cs_n & ~end_r;
endmodule
`default_nettype wire

// File: dar_host.sv
// dar_host.sv: host end of the dual result serial readout
// Assumes dar_defs.svh and dar_pkg come first; the link is joined by dar_if
// Contract
// - Serial clock between 200 kHz and 34 MHz
// - Conversion ends within nineteen serial clocks
// - Results released after nineteenth falling edge
// - New result bit after each falling edge
// - Configuration bit captured on falling edge
// - Chip select high releases both result lines
// - Chip select high 13 ns between frames
// - Serial clock phases each at least 0.4 period
// - Calibration pin held high at least 2 us
// - Wait 2 us after calibration before frame; the host can drop chip select one cycle after cal falls
// - Wait power-up time before relying on conversions
`timescale 1ns/1ps
`default_nettype none
`include "dar_defs.svh"
module dar_host
#(
    parameter int PWRUP_CYC = `DAR_CYC_MIN(`DAR_PWRUP_NS)
)
(
    input  wire logic               i_clock,
    input  wire logic               i_resetn,
    input  wire logic               i_start,
    input  wire dar_pkg::dar_word_t i_cfg_word,
    input  wire logic               i_cal_req,
    output logic                    o_powered,
    output logic                    o_busy,
    output logic                    o_res_valid,
    input  wire logic               i_res_ready,
    output dar_pkg::dar_word_t      o_res_first,
    output dar_pkg::dar_word_t      o_res_second,
    dar_if.host                     bus
);
    import dar_pkg::*;

    // ****************************************
    // Sequencer state
    // ****************************************
    dar_hstate_e           state_r;
    dar_hstate_e           state_nxt;
    logic [`DAR_TMR_W-1:0] tmr_r;
    logic [`DAR_TMR_W-1:0] tmr_nxt;
    logic [`DAR_CNT_W-1:0] fall_r;
    logic [`DAR_CNT_W-1:0] fall_nxt;
    logic                  sclk_r;
    logic                  sclk_nxt;
    logic                  cs_n_r;
    logic                  cs_n_nxt;
    logic                  cal_r;
    logic                  cal_nxt;
    logic                  cfg_r;
    logic                  cfg_nxt;
    logic                  cal_pend_r;
    logic                  cal_pend_nxt;
    dar_word_t             cfg_sh_r;
    dar_word_t             cfg_sh_nxt;
    dar_word_t             rx_a_r;
    dar_word_t             rx_a_nxt;
    dar_word_t             rx_b_r;
    dar_word_t             rx_b_nxt;

    // ****************************************
    // Result line synchronisers and buffer
    // ****************************************
    logic                      a_s1_r;
    logic                      a_s2_r;
    logic                      b_s1_r;
    logic                      b_s2_r;
    dar_word_t                 mem_a [`DAR_BUF_DEPTH];
    dar_word_t                 mem_b [`DAR_BUF_DEPTH];
    logic                      wp_r;
    logic                      rp_r;
    logic [`DAR_BUF_CNT_W-1:0] fill_r;

    // Timer reload values, rounded up to whole cycles
    wire [`DAR_TMR_W-1:0] half_ld  = `DAR_TMR_W'(`DAR_SCLK_HALF - 1);
    wire [`DAR_TMR_W-1:0] setup_ld = `DAR_TMR_W'(`DAR_CYC_MIN(`DAR_CS_SETUP_NS) - 1);
    wire [`DAR_TMR_W-1:0] quiet_ld = `DAR_TMR_W'(`DAR_CYC_MIN(`DAR_QUIET_NS) - 1);
    wire [`DAR_TMR_W-1:0] cal_ld   = `DAR_TMR_W'(`DAR_CYC_MIN(`DAR_CAL_HIGH_NS) - 1);
    wire [`DAR_TMR_W-1:0] pwr_ld   = `DAR_TMR_W'(PWRUP_CYC - 1);

    // Frame decode
    wire tmr_done  = tmr_r == '0;
    wire buf_full  = fill_r == `DAR_BUF_CNT_W'(`DAR_BUF_DEPTH);
    wire last_fall = fall_r == `DAR_CNT_W'(`DAR_FRAME_EDGES);
    wire take_bit  = (fall_r >= `DAR_CNT_W'(`DAR_SAMPLE_FIRST)) &&
                     (fall_r <= `DAR_CNT_W'(`DAR_SAMPLE_LAST));
    wire in_frame  = state_r == HS_FRAME;
    wire frame_end = in_frame && tmr_done && !sclk_r && last_fall;
    wire cal_take  = (state_r == HS_IDLE) && cal_pend_r;
    wire push      = frame_end;
    wire pop       = o_res_valid & i_res_ready;

    // Sequencer next state
    always_comb
    begin
        state_nxt  = state_r;
        tmr_nxt    = tmr_done ? tmr_r : tmr_r - `DAR_TMR_W'(1);
        fall_nxt   = fall_r;
        sclk_nxt   = sclk_r;
        cs_n_nxt   = cs_n_r;
        cal_nxt    = cal_r;
        cfg_nxt    = cfg_r;
        cfg_sh_nxt = cfg_sh_r;
        rx_a_nxt   = rx_a_r;
        rx_b_nxt   = rx_b_r;
        unique case (state_r)
            HS_PWRUP:
            begin
                if (tmr_done)
                    state_nxt = HS_IDLE;
            end
            HS_IDLE:
            begin
                if (cal_pend_r)
                begin
                    state_nxt = HS_CAL;
                    cal_nxt   = 1'b1;
                    tmr_nxt   = cal_ld;
                end
                else if (i_start && !buf_full)
                begin
                    state_nxt  = HS_SETUP;
                    cs_n_nxt   = 1'b0;
                    tmr_nxt    = setup_ld;
                    fall_nxt   = '0;
                    cfg_nxt    = i_cfg_word[`DAR_RES_W-1];
                    cfg_sh_nxt = {i_cfg_word[`DAR_RES_W-2:0], 1'b0};
                end
            end
            HS_CAL:
            begin
                if (tmr_done)
                begin
                    state_nxt = HS_IDLE;
                    cal_nxt   = 1'b0;
                end
            end
            HS_SETUP:
            begin
                if (tmr_done)
                begin
                    state_nxt = HS_FRAME;
                    tmr_nxt   = half_ld;
                end
            end
            HS_FRAME:
            begin
                if (tmr_done && sclk_r)
                begin
                    sclk_nxt = 1'b0;
                    tmr_nxt  = half_ld;
                    fall_nxt = fall_r + `DAR_CNT_W'(1);
                    if (take_bit)
                    begin
                        rx_a_nxt = {rx_a_r[`DAR_RES_W-2:0], a_s2_r};
                        rx_b_nxt = {rx_b_r[`DAR_RES_W-2:0], b_s2_r};
                    end
                end
                else if (tmr_done)
                begin
                    sclk_nxt   = 1'b1;
                    tmr_nxt    = half_ld;
                    cfg_nxt    = cfg_sh_r[`DAR_RES_W-1];
                    cfg_sh_nxt = {cfg_sh_r[`DAR_RES_W-2:0], 1'b0};
                    if (last_fall)
                    begin
                        state_nxt = HS_QUIET;
                        cs_n_nxt  = 1'b1;
                        tmr_nxt   = quiet_ld;
                    end
                end
            end
            HS_QUIET:
            begin
                if (tmr_done)
                    state_nxt = HS_IDLE;
            end
        endcase
    end

    // Calibration request is sticky; a new request wins over the take
    assign cal_pend_nxt = i_cal_req | (cal_pend_r & ~cal_take);

    // Sequencer registers
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_r <= HS_PWRUP;
            tmr_r   <= pwr_ld;
            fall_r  <= '0;
            sclk_r  <= 1'b1;
            cs_n_r  <= 1'b1;
            cal_r   <= 1'b0;
            cfg_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
            fall_r  <= fall_nxt;
            sclk_r  <= sclk_nxt;
            cs_n_r  <= cs_n_nxt;
            cal_r   <= cal_nxt;
            cfg_r   <= cfg_nxt;
        end
    end

    // Shift registers and pending calibration
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cal_pend_r <= 1'b0;
            cfg_sh_r   <= '0;
            rx_a_r     <= '0;
            rx_b_r     <= '0;
        end
        else
        begin
            cal_pend_r <= cal_pend_nxt;
            cfg_sh_r   <= cfg_sh_nxt;
            rx_a_r     <= rx_a_nxt;
            rx_b_r     <= rx_b_nxt;
        end
    end

    // Result lines pass two flip-flops before use
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            {a_s1_r, a_s2_r} <= '0;
            {b_s1_r, b_s2_r} <= '0;
        end
        else
        begin
            {a_s1_r, a_s2_r} <= {bus.res_first_o, a_s1_r};
            {b_s1_r, b_s2_r} <= {bus.res_second_o, b_s1_r};
        end
    end

    // Two-entry result buffer; a full buffer holds off the next frame
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wp_r   <= 1'b0;
            rp_r   <= 1'b0;
            fill_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= ~wp_r;
            if (pop)
                rp_r <= ~rp_r;
            if (push && !pop)
                fill_r <= fill_r + `DAR_BUF_CNT_W'(1);
            else if (pop && !push)
                fill_r <= fill_r - `DAR_BUF_CNT_W'(1);
        end
    end

    // Buffer storage, written at frame end
    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            mem_a[wp_r] <= rx_a_r;
            mem_b[wp_r] <= rx_b_r;
        end
    end

    // User side outputs
    assign o_res_valid  = fill_r != '0;
    assign o_res_first  = mem_a[rp_r];
    assign o_res_second = mem_b[rp_r];
    assign o_powered    = state_r != HS_PWRUP;
    assign o_busy       = (state_r != HS_IDLE) | cal_pend_r;

    // Link pins
    assign bus.cs_n    = cs_n_r;
    assign bus.sclk    = sclk_r;
    assign bus.cfg_din = cfg_r;
    assign bus.cal     = cal_r;
endmodule
`default_nettype wire

// File: dar_chk.sv
// dar_chk.sv: link assertions between the host and converter ends
// Assumes the plain dar_if signals and the host clock domain
`timescale 1ns/1ps
`default_nettype none
`include "dar_defs.svh"
module dar_chk
(
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic cfg_din,
    input  wire logic cal,
    input  wire logic res_first_o,
    input  wire logic res_first_oe,
    input  wire logic res_second_o,
    input  wire logic res_second_oe
);
    localparam int CAL_MIN = `DAR_CYC_MIN(`DAR_CAL_HIGH_NS);
    logic        sclk_d_r;
    logic [4:0]  falls_r;
    logic [15:0] cal_cnt_r;
    // ********************************
    // Helper counters
    // ********************************
    // Falling serial clock edges in a frame, and calibration high time
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sclk_d_r  <= 1'b1;
            falls_r   <= '0;
            cal_cnt_r <= '0;
        end
        else
        begin
            sclk_d_r  <= sclk;
            falls_r   <= cs_n ? 5'h00 : falls_r + 5'((sclk_d_r & ~sclk));
            cal_cnt_r <= cal ? cal_cnt_r + 16'h0001 : 16'h0000;
        end
    end
    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    a_idle_released: assert property (cs_n |-> !res_first_oe && !res_second_oe)
        else $error("result lines driven while deselected");
    a_tail_released: assert property (!cs_n && falls_r == 5'h13 |-> !res_first_oe && !res_second_oe)
        else $error("result lines driven after last fall");
    a_lines_driven: assert property (!cs_n && falls_r < 5'h12 |-> res_first_oe && res_second_oe)
        else $error("result lines not driven in frame");
    a_tail_zero: assert property (!cs_n && falls_r >= 5'h10 && falls_r <= 5'h11 |-> !res_first_o && !res_second_o)
        else $error("tail bits not zero");
    a_frame_falls: assert property ($rose(cs_n) |-> falls_r == 5'h13)
        else $error("frame did not hold nineteen falls");
    a_conv_bound: assert property ($fell(cs_n) |-> ##[1:200] $rose(cs_n))
        else $error("frame too long");
    a_sclk_low: assert property ($fell(sclk) |-> ##1 !sclk [*3] ##1 sclk)
        else $error("serial clock low phase wrong");
    a_sclk_high: assert property ($rose(sclk) && !cs_n |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase wrong");
    a_cs_quiet: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("chip select gap too short");
    a_cfg_hold: assert property (!cs_n && $fell(sclk) |-> $stable(cfg_din))
        else $error("config bit moved at capture");
    a_cal_width: assert property ($fell(cal) |-> cal_cnt_r >= CAL_MIN)
        else $error("calibration pulse too short");
    a_cal_no_frame: assert property (cal |-> cs_n)
        else $error("frame during calibration");
endmodule
`default_nettype wire

// File: dual_adc_serial_readout_bench.sv
// dual_adc_serial_readout_bench.sv: host and converter ends joined back to back
// Assumes the design files, dar_if and dar_chk are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dar_defs.svh"
module dual_adc_serial_readout_bench;
    import dar_pkg::*;
    localparam dar_word_t CFG = 14'h2b61;
    localparam dar_word_t WA  = 14'h1a5c;
    localparam dar_word_t WB  = 14'h0e37;
    logic      clock, resetn, start, cal_req, res_ready, s_valid;
    logic      powered, busy, res_valid, s_ready, frame_done, cal_start;
    dar_word_t res_first, res_second, cfg_got;
    int        err_total, checks_done, done_cnt;
    dar_if link();
    wire       res_first_w  = link.res_first_oe ? link.res_first_o : 1'bz;
    wire       res_second_w = link.res_second_oe ? link.res_second_o : 1'bz;
    dar_host #(.PWRUP_CYC(20)) i_dar_host
        (.i_clock(clock), .i_resetn(resetn), .i_start(start), .i_cfg_word(CFG), .i_cal_req(cal_req),
         .o_powered(powered), .o_busy(busy), .o_res_valid(res_valid), .i_res_ready(res_ready),
         .o_res_first(res_first), .o_res_second(res_second), .bus(link));
    dar_dev i_dar_dev
        (.i_clock(clock), .i_resetn(resetn), .i_sample_valid(s_valid), .i_sample_first(WA),
         .i_sample_second(WB), .o_sample_ready(s_ready), .o_cfg_word(cfg_got),
         .o_frame_done(frame_done), .o_cal_start(cal_start), .bus(link));
    dar_chk i_dar_chk
        (.i_clock(clock), .i_resetn(resetn), .cs_n(link.cs_n), .sclk(link.sclk), .cfg_din(link.cfg_din),
         .cal(link.cal), .res_first_o(link.res_first_o), .res_first_oe(link.res_first_oe),
         .res_second_o(link.res_second_o), .res_second_oe(link.res_second_oe));
    // ********************************
    // Helpers
    // ********************************
    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk14(input string what, input dar_word_t exp, input dar_word_t got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Count cycles with chip select low over a span
    task automatic count_low(input int span, output int lows);
        lows = 0;
        repeat (span)
        begin
            step(1);
            if (link.cs_n !== 1'b1) lows++;
        end
    endtask
    // Take the buffer head, then pop it
    task automatic pop(output dar_word_t a, output dar_word_t b);
        int n;
        for (n = 0; n < 1000 && res_valid !== 1'b1; n++) step(1);
        a = res_first;
        b = res_second;
        res_ready = 1'b1;
        step(1);
        res_ready = 1'b0;
        step(1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic scen_powerup;
        int n, lows;
        s_valid = 1'b1;
        for (n = 0; n < 20 && s_ready !== 1'b1; n++) step(1);
        step(1);
        s_valid = 1'b0;
        chk1("sample_taken", 1'b0, s_ready);
        start = 1'b1;
        count_low(8, lows);
        chk14("early_frames", 14'h0000, 14'(lows));
        for (n = 0; n < 40 && powered !== 1'b1; n++) step(1);
        chk1("powered", 1'b1, powered);
    endtask
    task automatic scen_fill_drain;
        int lows;
        dar_word_t a, b;
        step(700);
        count_low(300, lows);
        chk14("frames_when_full", 14'h0000, 14'(lows));
        chk14("frames_done", 14'h0002, 14'(done_cnt));
        chk14("cfg_word", CFG, cfg_got);
        chk1("sample_ready", 1'b1, s_ready);
        start = 1'b0;
        pop(a, b);
        chk14("idle_first", 14'h0000, a);
        chk14("idle_second", 14'h0000, b);
        pop(a, b);
        chk14("res_first", WA, a);
        chk14("res_second", WB, b);
        chk1("buffer_empty", 1'b0, res_valid);
    endtask
    task automatic scen_cal;
        int n;
        res_ready = 1'b1;
        cal_req = 1'b1;
        step(1);
        cal_req = 1'b0;
        start = 1'b1;
        for (n = 0; n < 50 && cal_start !== 1'b1; n++) step(1);
        chk1("cal_start", 1'b1, cal_start);
        chk1("cal_busy", 1'b1, busy);
        for (n = 0; n < 1000 && link.cs_n !== 1'b0; n++) step(1);
        chk1("frame_after_cal", 1'b0, link.cs_n);
        chk1("cal_low_in_frame", 1'b0, link.cal);
    endtask
    task automatic scen_reset_mid;
        step(40);
        chk1("line_driven", 1'b1, link.res_first_oe);
        resetn = 1'b0;
        #1;
        chk1("cs_released", 1'b1, link.cs_n);
        chk1("first_hiz", 1'bz, res_first_w);
        chk1("second_hiz", 1'bz, res_second_w);
        chk1("valid_cleared", 1'b0, res_valid);
        step(3);
        resetn = 1'b1;
        start = 1'b0;
        step(30);
        chk1("powered_again", 1'b1, powered);
    endtask
    // ********************************
    // Clock, reset, sequence, watchdog
    // ********************************
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Count frame done pulses away from the edge that launches them
    always @(negedge clock)
        if (frame_done === 1'b1) done_cnt++;
    initial
    begin
        resetn = 1'b0;
        start = 1'b0;
        cal_req = 1'b0;
        res_ready = 1'b0;
        s_valid = 1'b0;
        err_total = 0;
        checks_done = 0;
        done_cnt = 0;
        step(12);
        resetn = 1'b1;
        scen_powerup();
        scen_fill_drain();
        scen_cal();
        scen_reset_mid();
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
